/* File: hdl/rrc_hold_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module rrc_hold_timer #(
    parameter int unsigned CYCLES = 1,
    parameter int unsigned CW     = 20
) (
    input  wire logic core_clk,
    input  wire logic rst,
    output var  logic done
);

    logic [CW-1:0] cnt_q;

    generate
        if (CYCLES < 1 || CYCLES >= (64'd1 << CW)) begin : g_bad
            $error("rrc_hold_timer: CYCLES does not fit the counter");
        end
    endgenerate

    // ------------------------------------------------------------
    // Counts from reset release; done stays high once reached
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= '0;
            done  <= 1'b0;
        end else if (!done) begin
            cnt_q <= cnt_q + 1'b1;
            done  <= (cnt_q == CW'(CYCLES - 1));
        end
    end

endmodule

`default_nettype wire

/* File: hdl/rrc_pkg.sv */
`default_nettype none

package rrc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CORE_CLK_HZ     = 10_000_000;
    // Power-up hold of the processor reset, in microseconds
    localparam int unsigned POR_HOLD_US     = 100_000;
    localparam int unsigned POR_HOLD_CYC    = (POR_HOLD_US * (CORE_CLK_HZ / 1_000_000) < 1) ? 1 :
                                              POR_HOLD_US * (CORE_CLK_HZ / 1_000_000);

    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam logic [31:0] ROM_BASE        = 32'h0080_0000;
    localparam logic [31:0] ROM_SPAN        = 32'h0004_0000;
    localparam logic [31:0] RAM_BASE        = 32'h0000_0000;
    localparam logic [31:0] RAM_SPAN        = 32'h0020_0000;
    localparam logic [31:0] VEC_PC_ADDR     = 32'h0000_0004;

    // ------------------------------------------------------------
    // Coprocessor space decode
    // ------------------------------------------------------------
    localparam logic [2:0]  FC_CPU_SPACE    = 3'h7;
    localparam logic [3:0]  CPU_SPACE_COPRO = 4'h2;
    localparam logic [2:0]  COPRO_ID_FPU    = 3'h1;

    // ------------------------------------------------------------
    // Status contribution
    // ------------------------------------------------------------
    localparam int unsigned STAT_COPRO_BIT  = 6;
    localparam logic [7:0]  STAT_RESET_VAL  = 8'h00;

    typedef enum logic [1:0] {
        SEQ_POWER = 2'b00,
        SEQ_HW    = 2'b01,
        SEQ_SW    = 2'b10,
        SEQ_RUN   = 2'b11
    } rrc_seq_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [2:0]  fc;
        logic        strobe;
        logic        rd;
        logic        done;
    } rrc_bus_t;

    typedef struct packed {
        logic        rom;
        logic        ram;
        logic        fpu;
    } rrc_sel_t;

endpackage

`default_nettype wire

/* File: hdl/rrc_reset_overlay.sv */
// How it works
// - Hold processor reset until power stable
// - Power, switch, expansion reset act alike
// - Any reset resets all on-board controllers
// - Drive reset to disk and expansion outputs
// - Non-power resets leave RAM untouched
// - Every reset maps ROM over low memory
// - Software reset spares only the processor
// - Software reset also enables the overlay
// - Overlay: ROM answers high and low
// - Second vector read removes the overlay
// - Low address 4 read ends overlay
// - Strap drives processor cache disable input
// - Coprocessor identifier 001 selects the FPU
// - Status bit shows coprocessor socket fitted
// - Fitted flag is status bit 6
// - Halt indicator lights whenever processor halted
// - Diagnostic indicator follows floppy side select
`timescale 1ns/1ps
`default_nettype none

module rrc_reset_overlay
    import rrc_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_HOLD_CYC,
    parameter int unsigned POR_CW     = 20,
    parameter int unsigned ROM_AW     = 18
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              reset_switch_n,
    input  wire logic              exp_reset_in_n,
    input  wire logic              cpu_reset_instr,
    input  wire rrc_bus_t          cpu_bus,
    input  wire logic              cache_inhibit_strap,
    input  wire logic              copro_fitted,
    input  wire logic              cpu_halted,
    input  wire logic              step_hold,
    input  wire logic              floppy_side_select,
    output var  logic              cpu_reset_n,
    output var  logic              copro_reset_n,
    output var  logic              serial_reset_n,
    output var  logic              parallel_reset_n,
    output var  logic              floppy_reset_n,
    output var  logic              disk_reset_n,
    output var  logic              disk_reset_out_n,
    output var  logic              exp_reset_out_n,
    output var  logic              overlay_active,
    output var  rrc_sel_t          sel,
    output var  logic [ROM_AW-1:0] rom_offset,
    output var  logic              cache_disable,
    output var  logic [7:0]        disk_status_copro,
    output var  logic              halt_indicator,
    output var  logic              diagnostic_indicator
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (ROM_AW < 3 || ROM_AW > 23) begin : g_bad_aw
            $error("rrc_reset_overlay: ROM_AW out of range");
        end
        if (POR_CYCLES < 1) begin : g_bad_por
            $error("rrc_reset_overlay: POR_CYCLES must be positive");
        end
        if (POR_CYCLES >= (64'd1 << POR_CW)) begin : g_bad_cw
            $error("rrc_reset_overlay: POR_CYCLES does not fit POR_CW");
        end
        if ((64'd1 << ROM_AW) < ROM_SPAN) begin : g_bad_span
            $error("rrc_reset_overlay: ROM_AW too narrow for the ROM");
        end
    endgenerate

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic in_window(input logic [31:0] a,
                                       input logic [31:0] base,
                                       input logic [31:0] span);
        in_window = (a >= base) && (a < base + span);
    endfunction

    // CPU space carries control cycles only, never memory
    function automatic logic is_mem_space(input logic [2:0] fc);
        is_mem_space = (fc != FC_CPU_SPACE);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Debounce is done off-board; these flops only stop metastability
    // Reset pins are low-active outside; invert before syncing so
    // the synchroniser's reset value reads as "not requested".
    logic [3:0] pin_raw;
    logic [3:0] pin_sync;

    assign pin_raw = {~reset_switch_n,
                      ~exp_reset_in_n,
                      cache_inhibit_strap,
                      copro_fitted};

    rrc_sync #(
        .W        (4)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (pin_raw),
        .q        (pin_sync)
    );

    logic switch_req;
    logic exp_req;
    logic strap_fitted;
    logic copro_seen;

    assign switch_req   = pin_sync[3];
    assign exp_req      = pin_sync[2];
    assign strap_fitted = pin_sync[1];
    assign copro_seen   = pin_sync[0];

    // ------------------------------------------------------------
    // Power-up hold
    // ------------------------------------------------------------
    logic por_done;

    // Timer saturates, so por_done never falls back once set
    // power-up hold
    rrc_hold_timer #(
        .CYCLES   (POR_CYCLES),
        .CW       (POR_CW)
    ) u_por (
        .core_clk (core_clk),
        .rst      (rst),
        .done     (por_done)
    );

    // ------------------------------------------------------------
    // Reset source classification
    // ------------------------------------------------------------
    logic hw_req;
    logic sw_req;
    logic any_req;

    assign hw_req  = !por_done || switch_req || exp_req;
    assign sw_req  = cpu_reset_instr;
    assign any_req = hw_req || sw_req;

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    // POWER is left once; later resets cycle through RUN, HW and SW
    rrc_seq_t seq_q;
    rrc_seq_t seq_d;

    always_comb begin
        seq_d = seq_q;
        unique case (seq_q)
            SEQ_POWER: begin
                if (por_done) begin
                    seq_d = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (hw_req) begin
                    seq_d = SEQ_HW;
                end else if (sw_req) begin
                    seq_d = SEQ_SW;
                end
            end
            SEQ_HW: begin
                if (!hw_req) begin
                    seq_d = sw_req ? SEQ_SW : SEQ_RUN;
                end
            end
            SEQ_SW: begin
                // A hardware source during a software reset escalates
                if (hw_req) begin
                    seq_d = SEQ_HW;
                end else if (!sw_req) begin
                    seq_d = SEQ_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            seq_q <= SEQ_POWER;
        end else begin
            seq_q <= seq_d;
        end
    end

    // ------------------------------------------------------------
    // Reset fan-out
    // ------------------------------------------------------------
    logic cpu_rst_d;
    logic dev_rst_d;

    assign cpu_rst_d = (seq_d == SEQ_POWER) || (seq_d == SEQ_HW);
    assign dev_rst_d = (seq_d != SEQ_RUN);

    // Taken from seq_d so every line moves on the sequencer's
    // own edge; one flop each keeps the lines glitch-free.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cpu_reset_n      <= 1'b0;
            copro_reset_n    <= 1'b0;
            serial_reset_n   <= 1'b0;
            parallel_reset_n <= 1'b0;
            floppy_reset_n   <= 1'b0;
            disk_reset_n     <= 1'b0;
            disk_reset_out_n <= 1'b0;
            exp_reset_out_n  <= 1'b0;
        end else begin
            cpu_reset_n      <= !cpu_rst_d;
            copro_reset_n    <= !dev_rst_d;
            serial_reset_n   <= !dev_rst_d;
            parallel_reset_n <= !dev_rst_d;
            floppy_reset_n   <= !dev_rst_d;
            disk_reset_n     <= !dev_rst_d;
            disk_reset_out_n <= !dev_rst_d;
            exp_reset_out_n  <= !dev_rst_d;
        end
    end

    // ------------------------------------------------------------
    // Overlay flag
    // ------------------------------------------------------------
    logic in_low_vec;
    logic vec_pc_read;
    logic ovl_set;
    logic ovl_clr;
    logic overlay_d;

    assign in_low_vec  = (cpu_bus.addr == VEC_PC_ADDR) && is_mem_space(cpu_bus.fc);
    assign vec_pc_read = overlay_active && cpu_bus.done && cpu_bus.rd && in_low_vec;

    assign ovl_set = any_req;
    // cleared once second vector is read
    assign ovl_clr = vec_pc_read;

    // reset sets, vector read clears; set wins
    // Set wins so a reset landing on the vector read still
    // leaves the ROM mapped for the restart fetch that follows.
    assign overlay_d = ovl_set ? 1'b1 :
                       ovl_clr ? 1'b0 :
                       overlay_active;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            overlay_active <= 1'b1;
        end else begin
            overlay_active <= overlay_d;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic              mem_cycle;
    logic              hit_rom_home;
    logic              hit_low;
    logic              hit_ram;
    logic              hit_fpu;
    logic              rom_d;
    logic              ram_d;
    logic              fpu_d;
    logic [ROM_AW-1:0] off_d;

    assign mem_cycle    = cpu_bus.strobe && is_mem_space(cpu_bus.fc);
    assign hit_rom_home = mem_cycle && in_window(cpu_bus.addr, ROM_BASE, ROM_SPAN);
    assign hit_low      = mem_cycle && in_window(cpu_bus.addr, RAM_BASE, ROM_SPAN);
    assign hit_ram      = mem_cycle && in_window(cpu_bus.addr, RAM_BASE, RAM_SPAN);

    // ROM at home and low while overlaid
    assign rom_d = hit_rom_home || (overlay_active && hit_low);
    // RAM never cleared; only hidden by overlay
    assign ram_d = hit_ram && !(overlay_active && hit_low);

    // Low and home windows share low address bits, so the offset
    // is the same slice for both: address 4 reads ROM byte 4.
    assign off_d = cpu_bus.addr[ROM_AW-1:0];

    assign hit_fpu = cpu_bus.strobe && !is_mem_space(cpu_bus.fc)
                     && (cpu_bus.addr[19:16] == CPU_SPACE_COPRO)
                     && (cpu_bus.addr[15:13] == COPRO_ID_FPU);
    assign fpu_d   = hit_fpu;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel        <= '0;
            rom_offset <= '0;
        end else begin
            sel.rom    <= rom_d;
            sel.ram    <= ram_d;
            sel.fpu    <= fpu_d;
            rom_offset <= rom_d ? off_d : '0;
        end
    end

    // ------------------------------------------------------------
    // Strap, status and indicators
    // ------------------------------------------------------------
    logic [7:0] stat_d;

    // socket presence only, no decode role
    // present flag on bit 6
    // Only a byte fragment; the status register ORs it in
    always_comb begin
        stat_d                 = STAT_RESET_VAL;
        stat_d[STAT_COPRO_BIT] = copro_seen;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cache_disable        <= 1'b0;
            disk_status_copro    <= STAT_RESET_VAL;
            halt_indicator       <= 1'b0;
            diagnostic_indicator <= 1'b0;
        end else begin
            cache_disable        <= strap_fitted;
            disk_status_copro    <= stat_d;
            halt_indicator       <= cpu_halted || step_hold;
            diagnostic_indicator <= floppy_side_select;
        end
    end

endmodule

`default_nettype wire

/* File: hdl/rrc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module rrc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    generate
        if (W < 1) begin : g_bad
            $error("rrc_sync: width must be at least one");
        end
    endgenerate

    // ------------------------------------------------------------
    // Two-stage synchroniser; first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

`default_nettype wire

/* File: tb/rrc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rrc_cpu_model
    import rrc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        cpu_reset_n,
    input  wire logic        go,
    input  wire logic        sw_go,
    input  wire logic [31:0] go_addr,
    input  wire logic [2:0]  go_fc,
    input  wire logic        go_rd,
    output var  rrc_bus_t    cpu_bus,
    output var  logic        cpu_reset_instr,
    output var  logic        busy
);
    logic run_q;

    // ------------------------------------------------
    // Bus cycle; released lines invert, never hold
    // ------------------------------------------------
    task automatic cycle(input logic [31:0] a, input logic [2:0] f, input logic r, input int w);
        @(posedge core_clk);
        cpu_bus <= '{addr: a, fc: f, strobe: 1'b1, rd: r, done: 1'b0};
        repeat (w) @(posedge core_clk);
        @(posedge core_clk);
        cpu_bus.done <= 1'b1;
        @(posedge core_clk);
        cpu_bus <= '{addr: ~a, fc: ~f, strobe: 1'b0, rd: ~r, done: 1'b0};
    endtask

    initial begin
        cpu_bus = '0;
        cpu_reset_instr = 1'b0;
        busy = 1'b0;
        run_q = 1'b0;
        forever begin
            @(posedge core_clk);
            if (cpu_reset_n && !run_q) begin
                busy <= 1'b1;
                cycle(RAM_BASE, 3'h5, 1'b1, 0);
                cycle(VEC_PC_ADDR, 3'h5, 1'b1, 2);
                busy <= 1'b0;
            end else if (sw_go) begin
                busy <= 1'b1;
                cycle(ROM_BASE + 32'h0000_0100, 3'h6, 1'b1, 1);
                cpu_reset_instr <= 1'b1;
                repeat (6) @(posedge core_clk);
                cpu_reset_instr <= 1'b0;
                cycle(VEC_PC_ADDR, 3'h5, 1'b1, 0);
                busy <= 1'b0;
            end else if (go) begin
                busy <= 1'b1;
                cycle(go_addr, go_fc, go_rd, 1);
                busy <= 1'b0;
            end
            run_q = cpu_reset_n;
        end
    end
endmodule

`default_nettype wire

/* File: tb/rrc_reset_overlay_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module rrc_reset_overlay_chk
    import rrc_pkg::*;
(
    input wire logic     core_clk,
    input wire logic     rst,
    input wire logic     reset_switch_n,
    input wire logic     exp_reset_in_n,
    input wire logic     cpu_reset_instr,
    input wire rrc_bus_t cpu_bus,
    input wire logic     cpu_halted,
    input wire logic     step_hold,
    input wire logic     floppy_side_select,
    input wire logic     cpu_reset_n,
    input wire logic     copro_reset_n,
    input wire logic     serial_reset_n,
    input wire logic     parallel_reset_n,
    input wire logic     floppy_reset_n,
    input wire logic     disk_reset_n,
    input wire logic     disk_reset_out_n,
    input wire logic     exp_reset_out_n,
    input wire logic     overlay_active,
    input wire rrc_sel_t sel,
    input wire logic     halt_indicator,
    input wire logic     diagnostic_indicator
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    // Pin sources still inside the synchroniser count as live
    logic [2:0] pin_q;
    wire        pins_quiet = reset_switch_n & exp_reset_in_n & (&pin_q);
    wire        dev_low = !(copro_reset_n | serial_reset_n | parallel_reset_n | floppy_reset_n | disk_reset_n);
    wire        rd4 = cpu_bus.done & cpu_bus.rd & (cpu_bus.addr == VEC_PC_ADDR) & (cpu_bus.fc != FC_CPU_SPACE);
    wire        halt_src = cpu_halted | step_hold;
    wire [2:0]  coprocessor_identifier = cpu_bus.addr[15:13];

    always_ff @(posedge core_clk) begin
        pin_q <= {pin_q[1:0], reset_switch_n & exp_reset_in_n};
    end

    a_sw_spares_cpu: assert property (
        cpu_reset_instr && cpu_reset_n && pins_quiet |=> cpu_reset_n) else $error("cpu reset by software reset");
    a_sw_resets_dev: assert property (
        $rose(cpu_reset_instr) |=> dev_low && overlay_active) else $error("software reset missed devices");
    a_ext_outs_follow: assert property (
        disk_reset_out_n == serial_reset_n && exp_reset_out_n == serial_reset_n) else $error("external reset differs");
    a_pin_resets_all: assert property (
        !(reset_switch_n && exp_reset_in_n) [*3] |=> !cpu_reset_n && dev_low && overlay_active)
        else $error("pin reset incomplete");
    a_overlay_clear: assert property (
        overlay_active && rd4 && pins_quiet && !cpu_reset_instr && cpu_reset_n |=> !overlay_active)
        else $error("overlay kept after vector read");
    a_overlay_hold: assert property (
        overlay_active && !rd4 |=> overlay_active) else $error("overlay dropped without vector read");
    a_rom_low_map: assert property (
        cpu_bus.strobe && cpu_bus.fc != FC_CPU_SPACE && cpu_bus.addr < 32'h0000_0008 && overlay_active
        |=> sel.rom && !sel.ram) else $error("low read not mapped to rom");
    a_fpu_select: assert property (
        cpu_bus.strobe && cpu_bus.fc == FC_CPU_SPACE && cpu_bus.addr[19:16] == CPU_SPACE_COPRO
        |=> sel.fpu == ($past(coprocessor_identifier) == COPRO_ID_FPU)) else $error("coprocessor select wrong");
    a_halt_lamp: assert property (
        1'b1 |=> halt_indicator == $past(halt_src)) else $error("halt lamp wrong");
    a_side_lamp: assert property (
        1'b1 |=> diagnostic_indicator == $past(floppy_side_select)) else $error("side lamp wrong");

    c_sw_reset: cover property ($rose(cpu_reset_instr));
    c_pin_reset: cover property ($fell(reset_switch_n));
    c_clear: cover property (overlay_active && rd4);
endmodule

bind rrc_reset_overlay rrc_reset_overlay_chk u_chk (.*);

`default_nettype wire

/* File: tb/rrc_reset_overlay_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module rrc_reset_overlay_tb
    import rrc_pkg::*;
;
    localparam int unsigned POR = 8;
    logic        core_clk = 1'b0;
    logic        rst, reset_switch_n, exp_reset_in_n, cache_inhibit_strap, copro_fitted;
    logic        cpu_halted, step_hold, floppy_side_select, go, sw_go, go_rd, busy, cpu_reset_instr;
    logic        cpu_reset_n, copro_reset_n, serial_reset_n, parallel_reset_n, floppy_reset_n, disk_reset_n;
    logic        disk_reset_out_n, exp_reset_out_n, overlay_active, cache_disable;
    logic        halt_indicator, diagnostic_indicator, stb_q;
    logic [2:0]  go_fc;
    logic [31:0] go_addr;
    logic [17:0] rom_offset;
    logic [7:0]  disk_status_copro;
    logic [6:0]  rsts;
    rrc_bus_t    cpu_bus;
    rrc_sel_t    sel;
    int          err_total = 0;
    int          comparisons = 0;
    int          ov_m = 1;
    logic [31:0] addrs [4] = '{32'h0, 32'h4, ROM_BASE + 32'h4, 32'h0001_0000};

    assign rsts = {copro_reset_n, serial_reset_n, parallel_reset_n, floppy_reset_n, disk_reset_n,
                   disk_reset_out_n, exp_reset_out_n};

    rrc_reset_overlay #(.POR_CYCLES(POR)) u_dut (.*);
    rrc_cpu_model u_cpu (.*);

    always #50 core_clk = ~core_clk;

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wait_until(input logic idle, output int n);
        n = 0;
        // Let the model's busy flag settle before polling it
        if (idle) @(posedge core_clk);
        while ((idle ? busy : cpu_reset_n) !== !idle && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 300) begin
            err_total++;
            test_done();
        end
    endtask

    task automatic bus_op(input logic [31:0] a, input logic [2:0] f);
        int n;
        go_addr <= a;
        go_fc <= f;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (3) @(posedge core_clk);
        wait_until(1'b1, n);
    endtask

    // Reference decode: rom overlays low memory while ov_m is set
    always @(posedge core_clk) begin
        logic low, hit;
        low = ov_m != 0 && cpu_bus.addr < ROM_SPAN;
        hit = low || (cpu_bus.addr >= ROM_BASE && cpu_bus.addr < ROM_BASE + ROM_SPAN);
        if (stb_q && cpu_bus.strobe && !rst) begin
            if (cpu_bus.fc == FC_CPU_SPACE) begin
                chk("fpu", sel.fpu, cpu_bus.addr[19:13] == {CPU_SPACE_COPRO, COPRO_ID_FPU});
            end else begin
                chk("rom", sel.rom, hit);
                chk("ram", sel.ram, !low && cpu_bus.addr < RAM_SPAN);
                if (hit) chk("offset", rom_offset, cpu_bus.addr[17:0]);
            end
        end
        if (cpu_bus.done && cpu_bus.rd && cpu_bus.addr == VEC_PC_ADDR && cpu_bus.fc != FC_CPU_SPACE) ov_m = 0;
        stb_q <= cpu_bus.strobe;
    end

    initial begin
        int n;
        logic [4:0] r;
        {rst, reset_switch_n, exp_reset_in_n, go_rd} = 4'hf;
        {cache_inhibit_strap, copro_fitted, cpu_halted, step_hold, floppy_side_select, go, sw_go} = 7'h0;
        go_fc = 3'h5;
        go_addr = 32'h0;
        void'($urandom(32'hf61fe701));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("por_cpu", cpu_reset_n, 0);
        chk("por_dev", rsts, 0);
        chk("por_ovl", overlay_active, 1);
        wait_until(1'b0, n);
        chk("por_len", n, POR + 1);
        wait_until(1'b1, n);
        chk("por_clear", overlay_active, 0);
        chk("run_dev", rsts, 7'h7f);
        foreach (addrs[i]) bus_op(addrs[i], 3'h5);
        repeat (4) bus_op($urandom & 32'h001f_fffc, 3'h5);
        for (int id = 0; id < 8; id++) bus_op({12'h0, CPU_SPACE_COPRO, id[2:0], 13'h0}, FC_CPU_SPACE);
        for (int k = 0; k < 2; k++) begin
            ov_m = 1;
            reset_switch_n <= k[0];
            exp_reset_in_n <= !k[0];
            repeat (6) @(posedge core_clk);
            chk("hw_cpu", cpu_reset_n, 0);
            chk("hw_dev", rsts, 0);
            chk("hw_ovl", overlay_active, 1);
            {reset_switch_n, exp_reset_in_n} <= 2'b11;
            wait_until(1'b0, n);
            wait_until(1'b1, n);
            chk("hw_clear", overlay_active, 0);
        end
        ov_m = 1;
        sw_go <= 1'b1;
        @(posedge core_clk);
        sw_go <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk("sw_cpu", cpu_reset_n, 1);
        chk("sw_dev", rsts, 0);
        chk("sw_ovl", overlay_active, 1);
        wait_until(1'b1, n);
        chk("sw_clear", overlay_active, 0);
        chk("sw_run", rsts, 7'h7f);
        repeat (16) begin
            r = 5'($urandom);
            {floppy_side_select, step_hold, cpu_halted, copro_fitted, cache_inhibit_strap} <= r;
            repeat (4) @(posedge core_clk);
            chk("cache", cache_disable, r[0]);
            chk("copro", disk_status_copro, {1'b0, r[1], 6'h0});
            chk("halt", halt_indicator, r[2] | r[3]);
            chk("diag", diagnostic_indicator, r[4]);
        end
        test_done();
    end
endmodule

`default_nettype wire
